// *** verilog/ssp_ctl.sv ***
// Control and status registers of the combined SPI / I2C serial port
//
// Notes on behaviour
// - Ten-bit client raises address-update flag when needed
// - I2C transmit: buffer full while sending, clear after
// - Receive: buffer full once byte complete
// - Acknowledge and stop bits never touch buffer-full
// - Start/stop status cleared by reset, disable
// - Client read/write bit from last matched address
// - Direction valid from match until start/stop/nack
// - Active when I2C host transmits or any sequence request set
// - Buffer write during shifting sets write collision
// - SPI client overrun sets overflow, drops byte
// - I2C receive overrun sets sticky overflow
// - Enable gives pins to port, else GPIO
// - SPI clock idle level follows polarity control
// - I2C client polarity zero stretches clock low
// - Codes 1111/1110: client with start/stop interrupts
// - Codes 0111/0110: client without start/stop interrupts
// - Code 1011: firmware host, client idle
// - Code 1010: SPI host, osc/(4*(n+1)), n>0
// - Codes 0101/0100: SPI client, select ignored/honoured
// - Code 0011: SPI host, timer output halved
// - Codes 0010/0001/0000: osc over 64/16/4
`timescale 1ns/1ps
module ssp_ctl (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [11:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire ssp_pkg::ssp_eng_in_t eng_in,
    output ssp_pkg::ssp_eng_out_t eng_out,
    input wire logic periodic_timer_output,
    input wire logic client_select_pin_n,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    output logic sck_sync,
    output logic pins_owned,
    output logic port_active,
    output logic rw_valid
);
    import ssp_pkg::*;

    logic [7:0] ctl1_reg;
    logic [7:0] addr_reg;
    logic [7:0] buf_reg;
    logic [4:0] req_reg;
    logic bf_reg;
    logic ua_reg;
    logic rw_reg;
    logic rwv_reg;
    logic start_reg;
    logic stop_reg;
    logic da_reg;
    logic [9:0] cnt_reg;
    logic sck_reg;
    logic tick_reg;
    logic tmr_prev_reg;
    logic [1:0] ss_sync_reg;
    logic [1:0] sck_sync_reg;

    logic [3:0] mode;
    logic en;
    logic clock_idle_release_ctl;
    logic spi_host;
    logic spi_client;
    logic i2c_client;
    logic i2c_host;
    logic is_i2c;
    logic ten_bit;
    logic active;
    logic wr_buf;
    logic rd_buf;
    logic wr_ctl1;
    logic overrun;
    logic rx_take;
    logic tmr_rise;
    logic [9:0] half;

    // Half period of the generated host clock, in oscillator cycles
    function automatic logic [9:0] half_period(input logic [3:0] m,
                                               input logic [7:0] n);
        logic [9:0] h;
        h = HALF_4;
        case (m)
            M_SPI_H_ADD, M_I2C_HOST: begin
                h = {1'b0, n, 1'b0} + 10'h0002;
            end
            M_SPI_H_64: begin
                h = HALF_64;
            end
            M_SPI_H_16: begin
                h = HALF_16;
            end
            default: begin
                h = HALF_4;
            end
        endcase
        return h;
    endfunction

    // Field views of control one
    assign mode = ctl1_reg[3:0];
    assign en = ctl1_reg[B_EN];
    assign clock_idle_release_ctl = ctl1_reg[B_CKP];

    // Mode decode; reserved codes fall into no group at all
    always_comb begin
        spi_host = 1'b0;
        spi_client = 1'b0;
        i2c_client = 1'b0;
        i2c_host = 1'b0;
        ten_bit = 1'b0;
        case (mode)
            M_I2C_C10_SS, M_I2C_C10: begin
                i2c_client = 1'b1;
                ten_bit = 1'b1;
            end
            M_I2C_C7_SS, M_I2C_C7: begin
                i2c_client = 1'b1;
            end
            M_I2C_FW, M_I2C_HOST: begin
                i2c_host = 1'b1;
            end
            M_SPI_C_NOSS, M_SPI_C_SS: begin
                spi_client = 1'b1;
            end
            M_SPI_H_ADD, M_SPI_H_TMR, M_SPI_H_64, M_SPI_H_16,
            M_SPI_H_4: begin
                spi_host = 1'b1;
            end
            default: begin
                spi_host = 1'b0;
            end
        endcase
    end

    assign is_i2c = i2c_client | i2c_host;
    // Host transmit in progress shows in the direction bit for I2C hosts
    assign active = (i2c_host & rw_reg) | (|req_reg);
    assign wr_buf = bus_wr && bus_addr == OFS_BUF;
    assign rd_buf = bus_rd && bus_addr == OFS_BUF;
    assign wr_ctl1 = bus_wr && bus_addr == OFS_CTL1;
    // Overflow only where the far side paces the bytes
    assign overrun = eng_in.rx_done & bf_reg & (spi_client | is_i2c);
    assign rx_take = eng_in.rx_done & ~overrun;
    assign tmr_rise = periodic_timer_output & ~tmr_prev_reg;
    assign half = half_period(mode, addr_reg);

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ss_sync_reg <= 2'b11;
            sck_sync_reg <= 2'b00;
        end else begin
            ss_sync_reg <= {ss_sync_reg[0], client_select_pin_n};
            sck_sync_reg <= {sck_sync_reg[0], sck_i};
        end
    end

    // Control one: software fields plus the two sticky error flags
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl1_reg <= RST_CTL1;
        end else begin
            if (wr_ctl1) begin
                ctl1_reg[5:0] <= bus_wdata[5:0];
                // Software may only clear the sticky flags
                if (!bus_wdata[B_WRITE_COLLISION_FLAG]) begin
                    ctl1_reg[B_WRITE_COLLISION_FLAG] <= 1'b0;
                end
                if (!bus_wdata[B_OVF]) begin
                    ctl1_reg[B_OVF] <= 1'b0;
                end
            end
            // Hardware set beats a same-cycle software clear
            if (en && wr_buf && (eng_in.tx_busy || active)) begin
                ctl1_reg[B_WRITE_COLLISION_FLAG] <= 1'b1;
            end
            if (en && overrun) begin
                ctl1_reg[B_OVF] <= 1'b1;
            end
        end
    end

    // Address / baud register; a write answers the update request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_reg <= RST_BYTE;
        end else if (bus_wr && bus_addr == OFS_ADDR) begin
            addr_reg <= bus_wdata;
        end
    end

    // Sequence requests: refused while active, cleared by the engine
    always_ff @(posedge clk) begin
        if (sys_rst || !en) begin
            req_reg <= RST_REQ;
        end else begin
            req_reg <= req_reg & ~eng_in.req_clear;
            if (bus_wr && bus_addr == OFS_CTL2 && !active) begin
                req_reg <= bus_wdata[4:0];
            end
        end
    end

    // Data buffer: received byte loads unless overrun, bus write only while idle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            buf_reg <= RST_BYTE;
        end else if (en && rx_take) begin
            buf_reg <= eng_in.rx_data;
        end else if (en && wr_buf && !eng_in.tx_busy && !active) begin
            buf_reg <= bus_wdata;
        end
    end

    // Buffer full; the engine flags only data bytes as complete
    always_ff @(posedge clk) begin
        if (sys_rst || !en) begin
            bf_reg <= 1'b0;
        end else if (rx_take) begin
            bf_reg <= 1'b1;
        end else if (is_i2c && wr_buf && !eng_in.tx_busy && !active) begin
            bf_reg <= 1'b1;
        end else if (is_i2c && eng_in.tx_done) begin
            bf_reg <= 1'b0;
        end else if (rd_buf) begin
            bf_reg <= 1'b0;
        end
    end

    // Address update flag, ten-bit client only
    always_ff @(posedge clk) begin
        if (sys_rst || !en || !(i2c_client && ten_bit)) begin
            ua_reg <= 1'b0;
        end else if (eng_in.ua_req) begin
            ua_reg <= 1'b1;
        end else if (bus_wr && bus_addr == OFS_ADDR) begin
            ua_reg <= 1'b0;
        end
    end

    // Direction bit: matched address in client, transmit in host
    always_ff @(posedge clk) begin
        if (sys_rst || !en) begin
            rw_reg <= 1'b0;
        end else if (i2c_host) begin
            rw_reg <= eng_in.tx_busy;
        end else if (i2c_client && eng_in.addr_match) begin
            rw_reg <= eng_in.addr_rw;
        end
    end

    // Window in which the client direction bit means anything
    always_ff @(posedge clk) begin
        if (sys_rst || !en || !i2c_client) begin
            rwv_reg <= 1'b0;
        end else if (eng_in.addr_match) begin
            rwv_reg <= 1'b1;
        end else if (eng_in.start_det || eng_in.stop_det ||
                     eng_in.nack_det) begin
            rwv_reg <= 1'b0;
        end
    end

    // Start / stop seen last; the newer event wins
    always_ff @(posedge clk) begin
        if (sys_rst || (wr_ctl1 && !bus_wdata[B_EN])) begin
            start_reg <= 1'b0;
            stop_reg <= 1'b0;
        end else if (en && is_i2c) begin
            if (eng_in.start_det) begin
                start_reg <= 1'b1;
                stop_reg <= 1'b0;
            end else if (eng_in.stop_det) begin
                start_reg <= 1'b0;
                stop_reg <= 1'b1;
            end
        end
    end

    // Data or address, last byte seen by the client
    always_ff @(posedge clk) begin
        if (sys_rst || !en) begin
            da_reg <= 1'b0;
        end else if (eng_in.addr_match) begin
            da_reg <= 1'b0;
        end else if (eng_in.rx_done || eng_in.tx_done) begin
            da_reg <= 1'b1;
        end
    end

    // Baud divider: one tick per half period of the host clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_reg <= RST_CNT;
            tick_reg <= 1'b0;
            tmr_prev_reg <= 1'b0;
        end else begin
            tmr_prev_reg <= periodic_timer_output;
            tick_reg <= 1'b0;
            if (!en || !(spi_host || i2c_host)) begin
                cnt_reg <= RST_CNT;
            end else if (mode == M_SPI_H_TMR) begin
                tick_reg <= tmr_rise;
            end else if (cnt_reg >= half - 10'h001) begin
                cnt_reg <= RST_CNT;
                tick_reg <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 10'h001;
            end
        end
    end

    // SPI host clock: toggles while shifting, rests at idle level
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sck_reg <= 1'b0;
        end else if (!(spi_host && eng_in.tx_busy)) begin
            sck_reg <= clock_idle_release_ctl;
        end else if (tick_reg) begin
            sck_reg <= ~sck_reg;
        end
    end

    // Clock pin: host drives, I2C lines only ever pull low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sck_o <= 1'b0;
            sck_oe <= 1'b0;
        end else if (!en) begin
            sck_o <= 1'b0;
            sck_oe <= 1'b0;
        end else if (spi_host) begin
            sck_o <= sck_reg;
            sck_oe <= 1'b1;
        end else if (i2c_client) begin
            sck_o <= 1'b0;
            sck_oe <= ~clock_idle_release_ctl | eng_in.scl_low;
        end else if (i2c_host) begin
            sck_o <= 1'b0;
            sck_oe <= eng_in.scl_low;
        end else begin
            sck_o <= 1'b0;
            sck_oe <= 1'b0;
        end
    end

    // Engine configuration and strobes, all registered
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            eng_out <= '0;
        end else begin
            eng_out.port_enable <= en;
            eng_out.mode <= mode;
            eng_out.i2c_client <= i2c_client & en;
            eng_out.ten_bit <= ten_bit;
            eng_out.startstop_irq <= i2c_client & mode[3];
            eng_out.fw_host <= mode == M_I2C_FW;
            eng_out.client_selected <= spi_client &
                ((mode == M_SPI_C_NOSS) | ~ss_sync_reg[1]);
            eng_out.baud_tick <= tick_reg;
            eng_out.tx_load <= en & wr_buf & ~eng_in.tx_busy & ~active;
            eng_out.tx_byte <= bus_wdata;
            eng_out.req <= req_reg;
        end
    end

    // Status levels toward the pins and the core
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pins_owned <= 1'b0;
            port_active <= 1'b0;
            rw_valid <= 1'b0;
            sck_sync <= 1'b0;
        end else begin
            pins_owned <= en;
            port_active <= active;
            rw_valid <= rwv_reg;
            sck_sync <= sck_sync_reg[1];
        end
    end

    // Read port, data one cycle after the strobe; others read zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_rdata <= RST_BYTE;
        end else if (!bus_rd) begin
            bus_rdata <= RST_BYTE;
        end else begin
            case (bus_addr)
                OFS_BUF: bus_rdata <= buf_reg;
                OFS_ADDR: bus_rdata <= addr_reg;
                OFS_STAT: bus_rdata <= {2'b00, da_reg, stop_reg, start_reg,
                                        rw_reg, ua_reg, bf_reg};
                OFS_CTL1: bus_rdata <= ctl1_reg;
                OFS_CTL2: bus_rdata <= {3'b000, req_reg};
                default: bus_rdata <= RST_BYTE;
            endcase
        end
    end
endmodule

// *** include/ssp_pkg.sv ***
// Constants, field layouts and carrier types of the serial port control block
package ssp_pkg;
    // Register byte addresses
    localparam logic [11:0] OFS_BUF = 12'h068C;
    localparam logic [11:0] OFS_ADDR = 12'h068D;
    localparam logic [11:0] OFS_STAT = 12'h068F;
    localparam logic [11:0] OFS_CTL1 = 12'h0690;
    localparam logic [11:0] OFS_CTL2 = 12'h0691;
    // Values after reset
    localparam logic [7:0] RST_CTL1 = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [4:0] RST_REQ = 5'h00;
    localparam logic [9:0] RST_CNT = 10'h000;
    // Control one field positions
    localparam int B_WRITE_COLLISION_FLAG = 7;
    localparam int B_OVF = 6;
    localparam int B_EN = 5;
    localparam int B_CKP = 4;
    // Control two request field positions (low five bits)
    localparam int B_SEN = 0;
    localparam int B_REPEAT_START_REQUEST = 1;
    localparam int B_PEN = 2;
    localparam int B_HOST_RECEIVE_REQUEST = 3;
    localparam int B_ACK_SEQUENCE_REQUEST = 4;
    // Mode selector codes
    localparam logic [3:0] M_I2C_C10_SS = 4'h0F;
    localparam logic [3:0] M_I2C_C7_SS = 4'h0E;
    localparam logic [3:0] M_RSVD_D = 4'h0D;
    localparam logic [3:0] M_RSVD_C = 4'h0C;
    localparam logic [3:0] M_I2C_FW = 4'h0B;
    localparam logic [3:0] M_SPI_H_ADD = 4'h0A;
    localparam logic [3:0] M_RSVD_9 = 4'h09;
    localparam logic [3:0] M_I2C_HOST = 4'h08;
    localparam logic [3:0] M_I2C_C10 = 4'h07;
    localparam logic [3:0] M_I2C_C7 = 4'h06;
    localparam logic [3:0] M_SPI_C_NOSS = 4'h05;
    localparam logic [3:0] M_SPI_C_SS = 4'h04;
    localparam logic [3:0] M_SPI_H_TMR = 4'h03;
    localparam logic [3:0] M_SPI_H_64 = 4'h02;
    localparam logic [3:0] M_SPI_H_16 = 4'h01;
    localparam logic [3:0] M_SPI_H_4 = 4'h00;
    // Clock divisors of the oscillator; half period is half of each
    localparam int DIV_64 = 64;
    localparam int DIV_16 = 16;
    localparam int DIV_4 = 4;
    localparam logic [9:0] HALF_64 = 10'(DIV_64 / 2);
    localparam logic [9:0] HALF_16 = 10'(DIV_16 / 2);
    localparam logic [9:0] HALF_4 = 10'(DIV_4 / 2);

    // Events and levels from the shift and sequence engine
    typedef struct packed {
        logic rx_done;
        logic [7:0] rx_data;
        logic tx_done;
        logic tx_busy;
        logic addr_match;
        logic addr_rw;
        logic start_det;
        logic stop_det;
        logic nack_det;
        logic ua_req;
        logic scl_low;
        logic [4:0] req_clear;
    } ssp_eng_in_t;

    // Configuration and strobes toward the engine
    typedef struct packed {
        logic port_enable;
        logic [3:0] mode;
        logic i2c_client;
        logic ten_bit;
        logic startstop_irq;
        logic fw_host;
        logic client_selected;
        logic baud_tick;
        logic tx_load;
        logic [7:0] tx_byte;
        logic [4:0] req;
    } ssp_eng_out_t;
endpackage

// *** tb/ssp_ctl_checker.sv ***
// Assertion checker for the serial port control block
`timescale 1ns/1ps
module ssp_ctl_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [11:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire ssp_pkg::ssp_eng_in_t eng_in,
    input wire ssp_pkg::ssp_eng_out_t eng_out,
    input wire logic periodic_timer_output,
    input wire logic client_select_pin_n,
    input wire logic sck_i,
    input wire logic sck_o,
    input wire logic sck_oe,
    input wire logic sck_sync,
    input wire logic pins_owned,
    input wire logic port_active,
    input wire logic rw_valid
);
    import ssp_pkg::*;
    logic ckp_q;
    logic ctl_wr;
    logic spi_host;
    logic i2c_cli;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Mode decode seen from the registered engine outputs
    assign ctl_wr = bus_wr && bus_addr == OFS_CTL1;
    assign spi_host = eng_out.port_enable
        && (eng_out.mode <= M_SPI_H_TMR || eng_out.mode == M_SPI_H_ADD);
    assign i2c_cli = eng_out.port_enable && eng_out.i2c_client;
    // Shadow of the polarity bit, which has no port of its own
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ckp_q <= 1'b0;
        end else if (ctl_wr) begin
            ckp_q <= bus_wdata[B_CKP];
        end
    end
    a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data not zero outside answer cycle");
    a_pins_follow: assert property (
        ctl_wr |-> ##2 pins_owned == $past(bus_wdata[B_EN], 2))
        else $error("pin ownership does not follow enable");
    a_oe_off: assert property (
        !pins_owned && $past(!pins_owned) |-> !sck_oe)
        else $error("clock pin driven while disabled");
    a_ckp_idle: assert property (
        (spi_host && !eng_in.tx_busy && $stable(ckp_q)) [*3]
        |-> sck_o == ckp_q)
        else $error("idle clock level differs from polarity");
    a_clk_stretch: assert property (
        (i2c_cli && $stable(ckp_q) && !eng_in.scl_low) [*3]
        |-> sck_oe == !ckp_q && sck_o == 1'b0)
        else $error("client clock hold wrong");
    a_active_req: assert property (
        (|eng_out.req) [*2] |-> port_active)
        else $error("port not active with request pending");
    a_rw_set: assert property (
        i2c_cli && eng_in.addr_match |-> ##[1:2] rw_valid)
        else $error("direction not valid after match");
    a_rw_clear: assert property (
        rw_valid && (eng_in.start_det || eng_in.stop_det || eng_in.nack_det)
        |-> ##[1:2] !rw_valid)
        else $error("direction window not closed");
    a_busy_load: assert property (
        bus_wr && bus_addr == OFS_BUF && eng_in.tx_busy
        |-> ##1 !eng_out.tx_load [*2])
        else $error("buffer loaded while shifting");
    cover property (ctl_wr && bus_wdata[B_EN]);
    cover property (eng_in.rx_done && eng_out.port_enable);
    cover property (rw_valid ##1 !rw_valid);
endmodule

// *** tb/ssp_eng_model.sv ***
// Behavioural engine and serial peer facing the control block
`timescale 1ns/1ps
module ssp_eng_model (
    input wire logic clk,
    output ssp_pkg::ssp_eng_in_t eng_in,
    output logic periodic_timer_output,
    output logic sck_i,
    output logic client_select_pin_n
);
    import ssp_pkg::*;
    ssp_eng_in_t pq = '0;
    logic busy = 1'b0;
    logic [2:0] div = 3'h0;
    // Pulses from the tasks with the shift level merged in
    always_comb begin
        eng_in = pq;
        eng_in.tx_busy = busy;
    end
    // Timer output free runs, period of eight clocks
    always @(posedge clk) begin
        div <= div + 3'h1;
    end
    assign periodic_timer_output = div[2];
    assign sck_i = 1'b1; // Pull-up on a released clock line
    logic sel_n = 1'b1;
    assign client_select_pin_n = sel_n;
    // Data bytes only; ack and stop never raise a receive pulse
    task automatic rx(input logic [7:0] d);
        @(posedge clk);
        pq.rx_done <= 1'b1;
        pq.rx_data <= d;
        @(posedge clk);
        pq.rx_done <= 1'b0;
        pq.rx_data <= ~d; // Released data shows no stale copy
    endtask
    // One engine event pulse
    task automatic ev(input int k, input logic b);
        ssp_eng_in_t v;
        v = '0;
        v.addr_rw = ~b;
        @(posedge clk);
        pq.addr_rw <= b;
        case (k)
            0: pq.addr_match <= 1'b1;
            1: pq.start_det <= 1'b1;
            2: pq.stop_det <= 1'b1;
            3: pq.ua_req <= 1'b1;
            4: pq.nack_det <= 1'b1;
            5: pq.tx_done <= 1'b1;
            default: pq.req_clear <= 5'h1F;
        endcase
        @(posedge clk);
        pq <= v;
    endtask
    task automatic hold(input logic b);
        @(posedge clk);
        busy <= b;
    endtask
    // Client select pin level, active low
    task automatic sel(input logic b);
        @(posedge clk);
        sel_n <= b;
    endtask
endmodule

// *** tb/ssp_ctl_tb.sv ***
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
module ssp_ctl_tb;
    import ssp_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] bus_addr = 12'h000;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_rdata;
    ssp_eng_in_t eng_in;
    ssp_eng_out_t eng_out;
    logic periodic_timer_output, client_select_pin_n, sck_i, sck_o, sck_oe;
    logic sck_sync, pins_owned, port_active, rw_valid;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    ssp_ctl i_dut (.clk, .sys_rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
        .bus_rdata, .eng_in, .eng_out, .periodic_timer_output,
        .client_select_pin_n, .sck_i, .sck_o, .sck_oe, .sck_sync,
        .pins_owned, .port_active, .rw_valid);
    ssp_eng_model i_peer (.clk, .eng_in, .periodic_timer_output, .sck_i,
        .client_select_pin_n);
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    // Read, mask and compare; data sampled mid-cycle once settled
    task automatic rc(input logic [11:0] a, input logic [7:0] m,
        input logic [7:0] exp);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(negedge clk);
        check(bus_rdata & m, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic t_reset();
        rc(OFS_CTL1, 8'hFF, RST_CTL1);
        rc(OFS_STAT, 8'hFF, 8'h00);
        rc(12'h000, 8'hFF, 8'h00); // Unmapped place reads zero
        check(pins_owned, 8'h00);
        check(sck_sync, 8'h01); // Pulled-up clock pin through both stages
    endtask
    task automatic t_modes();
        logic [3:0] m;
        logic cli;
        for (int i = 0; i < 16; i++) begin
            m = 4'(i);
            if (m == M_RSVD_9 || m == M_RSVD_C || m == M_RSVD_D) begin
                continue;
            end
            cli = m inside {M_I2C_C10_SS, M_I2C_C7_SS, M_I2C_C10, M_I2C_C7};
            wr(OFS_CTL1, {4'h2, m});
            rc(OFS_CTL1, 8'hFF, {4'h2, m});
            check(eng_out.mode, m);
            check(eng_out.i2c_client, cli);
            check(eng_out.ten_bit, cli & m[0]);
            check(eng_out.startstop_irq, cli & m[3]);
            check(eng_out.fw_host, m == M_I2C_FW);
            check(eng_out.client_selected, m == M_SPI_C_NOSS);
        end
    endtask
    // Distance between two divider ticks in the given mode
    task automatic gap(input logic [7:0] c, input int exp);
        int n;
        wr(OFS_CTL1, c);
        idle(2);
        n = 0;
        while (!eng_out.baud_tick && n < 99) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!eng_out.baud_tick && n < 99);
        check(8'(n), 8'(exp));
    endtask
    task automatic t_rx(input logic [7:0] c);
        wr(OFS_CTL1, c);
        i_peer.rx(8'h5A);
        rc(OFS_STAT, 8'h01, 8'h01);
        rc(OFS_BUF, 8'hFF, 8'h5A);
        rc(OFS_STAT, 8'h01, 8'h00);
        i_peer.ev(2, 1'b0);
        rc(OFS_STAT, 8'h01, 8'h00);
        i_peer.rx(8'h11);
        i_peer.rx(8'h22);
        rc(OFS_CTL1, 8'h40, 8'h40);
        rc(OFS_BUF, 8'hFF, 8'h11);
        wr(OFS_CTL1, c);
        rc(OFS_CTL1, 8'h40, 8'h00);
    endtask
    task automatic t_write_collision_flag();
        wr(OFS_CTL1, 8'h20);
        i_peer.hold(1'b1);
        wr(OFS_BUF, 8'hC3);
        rc(OFS_CTL1, 8'h80, 8'h80);
        wr(OFS_CTL1, 8'hA0); // A one written leaves the flag alone
        rc(OFS_CTL1, 8'h80, 8'h80);
        wr(OFS_CTL1, 8'h20);
        rc(OFS_CTL1, 8'h80, 8'h00);
        i_peer.hold(1'b0);
    endtask
    task automatic t_ua();
        wr(OFS_CTL1, 8'h26);
        i_peer.ev(3, 1'b0);
        rc(OFS_STAT, 8'h02, 8'h00);
        wr(OFS_CTL1, 8'h27);
        i_peer.ev(3, 1'b0);
        rc(OFS_STAT, 8'h02, 8'h02);
        wr(OFS_ADDR, 8'h05);
        rc(OFS_STAT, 8'h02, 8'h00);
    endtask
    task automatic t_rw();
        wr(OFS_CTL1, 8'h26);
        i_peer.ev(1, 1'b0);
        rc(OFS_STAT, 8'h18, 8'h08);
        i_peer.ev(0, 1'b1);
        rc(OFS_STAT, 8'h04, 8'h04);
        check(rw_valid, 8'h01);
        i_peer.ev(2, 1'b0);
        idle(2);
        check(rw_valid, 8'h00);
        rc(OFS_STAT, 8'h18, 8'h10);
        i_peer.ev(0, 1'b0);
        rc(OFS_STAT, 8'h04, 8'h00);
        i_peer.ev(4, 1'b0);
        idle(2);
        check(rw_valid, 8'h00);
        wr(OFS_CTL1, 8'h06);
        rc(OFS_STAT, 8'h18, 8'h00);
    endtask
    task automatic t_active();
        wr(OFS_CTL1, 8'h28);
        wr(OFS_CTL2, 8'h01);
        idle(2);
        check(port_active, 8'h01);
        check(eng_out.req, 8'h01);
        wr(OFS_BUF, 8'h77);
        rc(OFS_CTL1, 8'h80, 8'h80);
        i_peer.ev(6, 1'b0);
        idle(2);
        check(port_active, 8'h00);
        wr(OFS_CTL1, 8'h28);
    endtask
    // Client select honoured in mode 0100
    task automatic t_select(input logic b);
        wr(OFS_CTL1, {4'h2, M_SPI_C_SS});
        i_peer.sel(b);
        idle(4);
        check(eng_out.client_selected, !b);
    endtask
    // I2C transmit: buffer full from load until done
    task automatic t_tx();
        wr(OFS_CTL1, 8'h26);
        wr(OFS_BUF, 8'h3C);
        rc(OFS_STAT, 8'h01, 8'h01);
        i_peer.ev(5, 1'b0);
        rc(OFS_STAT, 8'h01, 8'h00);
    endtask
    // Level of the clock pin after settling in each setup
    task automatic pin(input logic [7:0] c, input logic o, input logic e);
        wr(OFS_CTL1, c);
        idle(4);
        check(sck_o, o);
        check(sck_oe, e);
    endtask
    // Timeout: a hang counts as a mismatch
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_modes();
        t_select(1'b0);
        t_select(1'b1);
        wr(OFS_ADDR, 8'h05);
        gap(8'h20, 2);
        gap(8'h21, 8);
        gap(8'h22, 32);
        gap(8'h23, 8);
        gap(8'h2A, 12);
        gap(8'h28, 12);
        t_rx(8'h25);
        t_rx(8'h26);
        t_tx();
        t_write_collision_flag();
        t_ua();
        t_rw();
        t_active();
        pin(8'h30, 1'b1, 1'b1);
        pin(8'h20, 1'b0, 1'b1);
        pin(8'h26, 1'b0, 1'b1);
        pin(8'h36, 1'b0, 1'b0);
        pin(8'h16, 1'b0, 1'b0);
        check(pins_owned, 8'h00);
        end_of_test();
    end
endmodule
bind ssp_ctl ssp_ctl_checker i_chk (.clk, .sys_rst, .bus_addr, .bus_wdata,
    .bus_wr, .bus_rd, .bus_rdata, .eng_in, .eng_out, .periodic_timer_output,
    .client_select_pin_n, .sck_i, .sck_o, .sck_oe, .sck_sync, .pins_owned,
    .port_active, .rw_valid);
